/* File: logic/opi_pkg.sv */
// Shared constants for the dual-role controller pin interface: register map, fields, resets, straps
`default_nettype none
package opi_pkg;

	// ------------------------
	// Bus widths
	// ------------------------
	localparam int DATA_W = 16; // Host data bus width
	localparam int ADDR_W = 8; // Host register index width

	// ------------------------
	// Register indices on the host register bus
	// ------------------------
	localparam logic [7:0] IDX_PIN_CFG = 8'h00; // Drive modes of the CPU-side outputs
	localparam logic [7:0] IDX_OTG_CTRL = 8'h01; // VBUS and D+ resistor enables
	localparam logic [7:0] IDX_PIN_STATUS = 8'h02; // Sampled pins and strap decode, read only

	// ------------------------
	// Pin configuration fields
	// ------------------------
	localparam int CFG_W = 6;
	localparam int CFG_DREQ_EN = 0; // Request pin driven at all
	localparam int CFG_DREQ_HIGH = 1; // Request asserts high when set
	localparam int CFG_IRQ_EN = 2; // Interrupt pin driven at all
	localparam int CFG_IRQ_PP = 3; // Interrupt push-pull when set, else open-drain
	localparam int CFG_HOLD_EN = 4; // Hold pin driven at all
	localparam int CFG_HOLD_PP = 5; // Hold push-pull when set, else open-drain
	localparam logic [5:0] CFG_RESET = 6'h00;

	// ------------------------
	// OTG control fields
	// ------------------------
	localparam int OTG_W = 5;
	localparam int OTG_VBUS_3V3 = 0;
	localparam int OTG_VBUS_5V_LC = 1;
	localparam int OTG_VBUS_5V_HC = 2;
	localparam int OTG_PULLDOWN = 3;
	localparam int OTG_PULLUP = 4; // Set means pull-up enabled
	localparam logic [4:0] OTG_RESET = 5'h00;

	// ------------------------
	// Status fields
	// ------------------------
	localparam int ST_LOW_THR = 0;
	localparam int ST_HIGH_THR = 1;
	localparam int ST_ROLE_B = 2;
	localparam int ST_READY_STYLE = 3;
	localparam int ST_CLK_LSB = 4; // Two bits
	localparam int ST_TEST_LSB = 6; // Three bits
	localparam int ST_TEST_EN = 9;
	localparam int ST_NORMAL = 10;

	// ------------------------
	// Strap codes
	// ------------------------
	localparam logic [2:0] TEST_NORMAL = 3'h0;

	typedef enum logic [1:0] {
		OPI_CLK_RES_12 = 2'h0, // 12 MHz resonator
		OPI_CLK_EXT_27 = 2'h1, // External 27 MHz
		OPI_CLK_EXT_48 = 2'h2, // External 48 MHz
		OPI_CLK_EXT_12 = 2'h3 // External 12 MHz
	} opi_clk_src_e;

endpackage
`default_nettype wire

/* File: logic/opi_if.sv */
// Pin bundle between the controller and its CPU/DMA master and board circuitry
`timescale 1ns/1ps
`default_nettype none
interface opi_if;

	// ------------------------
	// CPU and DMA pins
	// ------------------------
	logic chip_select_n;
	logic cpu_read_strobe_n;
	logic cpu_write_strobe_n;
	logic [opi_pkg::ADDR_W-1:0] host_register_index;
	logic dma_acknowledge_in; // Active low
	logic burst_dma_strobe;
	logic [opi_pkg::DATA_W-1:0] dev_data_out; // Device half of the data bus
	logic dev_data_oe;
	logic [opi_pkg::DATA_W-1:0] cpu_data_out; // Master half of the data bus
	logic cpu_data_oe;
	logic [opi_pkg::DATA_W-1:0] host_data_bus; // Resolved level
	logic dma_request_out;
	logic dma_request_oe;
	logic cpu_irq_out;
	logic cpu_irq_oe;
	logic cpu_hold_out;
	logic cpu_hold_oe;
	logic dma_request_level; // Resolved, board pull-up assumed
	logic cpu_irq_level;
	logic cpu_hold_level;

	// ------------------------
	// Board side pins
	// ------------------------
	logic chip_reset_n;
	logic ready_style_strap;
	logic [1:0] clock_source_straps;
	logic [2:0] test_mode_straps;
	logic test_enable_in;
	logic pattern_test_in;
	logic scan_test_in;
	logic vbus_low_threshold_in;
	logic vbus_high_threshold_in;
	logic vbus_half_analog_in;
	logic otg_role_ident;
	logic vbus_3v3_enable;
	logic vbus_5v_low_current_enable;
	logic vbus_5v_high_current_enable;
	logic dplus_pulldown_enable;
	logic dplus_pullup_enable_n;

	// Undriven bus floats to zero here; released outputs float high
	assign host_data_bus = dev_data_oe ? dev_data_out : (cpu_data_oe ? cpu_data_out : '0);
	assign dma_request_level = dma_request_oe ? dma_request_out : 1'b1;
	assign cpu_irq_level = cpu_irq_oe ? cpu_irq_out : 1'b1;
	assign cpu_hold_level = cpu_hold_oe ? cpu_hold_out : 1'b1;

	modport dev (
		input chip_select_n, cpu_read_strobe_n, cpu_write_strobe_n, host_register_index,
		input dma_acknowledge_in, burst_dma_strobe, host_data_bus,
		output dev_data_out, dev_data_oe, dma_request_out, dma_request_oe,
		output cpu_irq_out, cpu_irq_oe, cpu_hold_out, cpu_hold_oe,
		input chip_reset_n, ready_style_strap, clock_source_straps, test_mode_straps,
		input test_enable_in, pattern_test_in, scan_test_in,
		input vbus_low_threshold_in, vbus_high_threshold_in, vbus_half_analog_in, otg_role_ident,
		output vbus_3v3_enable, vbus_5v_low_current_enable, vbus_5v_high_current_enable,
		output dplus_pulldown_enable, dplus_pullup_enable_n
	);

	modport cpu (
		output chip_select_n, cpu_read_strobe_n, cpu_write_strobe_n, host_register_index,
		output dma_acknowledge_in, burst_dma_strobe, cpu_data_out, cpu_data_oe,
		input host_data_bus, dma_request_level, cpu_irq_level, cpu_hold_level,
		output chip_reset_n, ready_style_strap, clock_source_straps, test_mode_straps,
		output test_enable_in, pattern_test_in, scan_test_in,
		output vbus_low_threshold_in, vbus_high_threshold_in, vbus_half_analog_in, otg_role_ident,
		input vbus_3v3_enable, vbus_5v_low_current_enable, vbus_5v_high_current_enable,
		input dplus_pulldown_enable, dplus_pullup_enable_n
	);

endinterface
`default_nettype wire

/* File: logic/opi_host.sv */
// CPU/DMA master and board end: register access, DMA pacing, straps and comparator wiring
`timescale 1ns/1ps
`default_nettype none
module opi_host #(
	parameter logic READY_STYLE = 1'b0, // Board strap level, fixed for the whole run
	parameter logic [1:0] CLOCK_SOURCE = 2'h0
) (
	input wire logic clock,
	input wire logic rst_n,
	opi_if.cpu pins,
	input wire logic [opi_pkg::ADDR_W-1:0] cmd_addr,
	input wire logic [opi_pkg::DATA_W-1:0] cmd_wdata,
	input wire logic cmd_write,
	input wire logic cmd_read,
	output logic [opi_pkg::DATA_W-1:0] cmd_rdata,
	input wire logic dma_write,
	input wire logic dma_read,
	input wire logic burst_mode,
	input wire logic burst_pulse,
	input wire logic clock_stable,
	input wire logic use_internal_comparator,
	input wire logic low_threshold,
	input wire logic high_threshold,
	input wire logic vbus_half_level,
	input wire logic role_ident,
	output logic dma_request_seen,
	output logic irq_seen,
	output logic hold_seen
);

	// ------------------------------------------------------------
	// State
	// ------------------------------------------------------------
	typedef struct packed {
		logic [opi_pkg::DATA_W-1:0] rdata; // Captured read data
		logic reset_released; // Chip reset let go
	} opi_host_s;

	opi_host_s st_reg; // Registered state
	opi_host_s st_next; // Next state

	// Strobes follow the command port directly so a read answers next cycle
	always_comb begin
		pins.chip_select_n = ~(cmd_write | cmd_read);
		pins.cpu_write_strobe_n = ~(cmd_write | dma_write);
		pins.cpu_read_strobe_n = ~(cmd_read | dma_read);
		pins.host_register_index = cmd_addr;
		pins.dma_acknowledge_in = ~(dma_write | dma_read);
		pins.cpu_data_out = cmd_wdata;
		pins.cpu_data_oe = cmd_write | dma_write;
		// Strobe held low unless burst pacing is in use
		pins.burst_dma_strobe = burst_mode & burst_pulse;
	end

	// Board straps and wiring
	always_comb begin
		pins.ready_style_strap = READY_STYLE;
		pins.clock_source_straps = CLOCK_SOURCE;
		pins.test_mode_straps = opi_pkg::TEST_NORMAL;
		pins.test_enable_in = 1'b0;
		pins.pattern_test_in = 1'b0;
		pins.scan_test_in = 1'b0;
		// Exactly one comparator path carries VBUS, the other is grounded
		pins.vbus_low_threshold_in = use_internal_comparator ? 1'b0 : low_threshold;
		pins.vbus_high_threshold_in = use_internal_comparator ? 1'b0 : high_threshold;
		pins.vbus_half_analog_in = use_internal_comparator ? vbus_half_level : 1'b0;
		pins.otg_role_ident = role_ident;
		pins.chip_reset_n = st_reg.reset_released;
	end

	// Next state
	always_comb begin
		st_next = st_reg;
		st_next.rdata = pins.host_data_bus;
		// Reset is released only after the clock has settled, and stays released
		if (clock_stable) begin
			st_next.reset_released = 1'b1;
		end
	end

	// State register
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

	assign cmd_rdata = st_reg.rdata;
	assign dma_request_seen = pins.dma_request_level;
	assign irq_seen = ~pins.cpu_irq_level;
	assign hold_seen = ~pins.cpu_hold_level;

endmodule
`default_nettype wire

/* File: logic/opi_device.sv */
// Controller end: CPU/DMA slave pins, OTG control outputs, VBUS inputs, strap decode
// Overview of operation
// - DMA request released after reset, polarity configurable
// - Interrupt released after reset; open-drain or push-pull
// - Hold released after reset; open-drain or push-pull
// - Ready strap high selects ready signalling
// - Data bus input unless CPU/DMA read
// - CPU presents register index every access
// - Burst strobe pulses pace DMA, else low
// - 3.3 V VBUS enable active high, reset off
// - Low-current 5 V enable active high, reset off
// - High-current 5 V enable active high, reset off
// - Low threshold input reads VBUS/2 above 1.0 V
// - High threshold input reads VBUS/2 above 2.2 V
// - Board grounds unused comparator path
// - D+ pull-down enable active high
// - D+ pull-up enable active low
// - Identification low means A role, high B
// - Clock straps select resonator or external clock
// - External clock stable before reset release
// - Test straps 000 mean normal operation
// - Test enable low normal; test inputs grounded
//
// The register addresses and strobed register access were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module opi_device #(
	parameter int DATA_W = opi_pkg::DATA_W,
	parameter int ADDR_W = opi_pkg::ADDR_W
) (
	input wire logic clock,
	input wire logic rst_n,
	opi_if.dev pins,
	input wire logic irq_request,
	input wire logic dma_request,
	input wire logic hold_request,
	input wire logic [DATA_W-1:0] dma_tx_word,
	output logic [DATA_W-1:0] dma_rx_word,
	output logic dma_rx_valid,
	output logic dma_tx_taken,
	output logic burst_strobe_seen,
	output logic [1:0] clock_source,
	output logic role_is_b,
	output logic vbus_above_1v0,
	output logic vbus_above_2v2,
	output logic normal_mode,
	output logic ready_mode
);

	// ------------------------
	// Elaboration checks
	// ------------------------
	// The register map and pin bundle are built for these widths only
	if (DATA_W != opi_pkg::DATA_W || ADDR_W != opi_pkg::ADDR_W) begin : g_width_check
		$error("opi_device: bus widths must match the pin bundle");
	end

	// ------------------------
	// State
	// ------------------------
	typedef struct packed {
		logic [opi_pkg::CFG_W-1:0] cfg; // Pin drive configuration
		logic [opi_pkg::OTG_W-1:0] otg; // VBUS and resistor control
		logic straps_taken; // Straps caught once after reset
		logic ready_style; // Caught ready strap
		logic [1:0] clk_src; // Caught clock straps
		logic [2:0] test_code; // Caught test straps
		logic test_en; // Test enable level
		logic low_thr; // Sampled comparator results
		logic high_thr;
		logic role_b; // Sampled identification
		logic [DATA_W-1:0] rx_word; // Last DMA write word
		logic rx_valid; // One-cycle pulse with the word
		logic strobe_prev; // Burst strobe edge detect
		logic strobe_seen; // One-cycle pulse per strobe
	} opi_dev_s;

	opi_dev_s st_reg; // Registered state
	opi_dev_s st_next; // Next state

	// ------------------------
	// Access decode
	// ------------------------
	logic cpu_sel; // CPU register access cycle
	logic dma_sel; // DMA data cycle
	logic reg_wr; // Register write this cycle
	logic reg_rd; // Register read this cycle
	logic dma_wr; // DMA word arriving
	logic dma_rd; // DMA word leaving
	logic [DATA_W-1:0] status_word; // Live status view
	logic [DATA_W-1:0] read_word; // Selected read data

	always_comb begin
		cpu_sel = ~pins.chip_select_n;
		dma_sel = ~pins.dma_acknowledge_in;
		reg_wr = cpu_sel & ~pins.cpu_write_strobe_n;
		reg_rd = cpu_sel & ~pins.cpu_read_strobe_n;
		dma_wr = dma_sel & ~cpu_sel & ~pins.cpu_write_strobe_n;
		dma_rd = dma_sel & ~cpu_sel & ~pins.cpu_read_strobe_n;
	end

	// Status word assembly; unused bits read as zero
	always_comb begin
		status_word = '0;
		status_word[opi_pkg::ST_LOW_THR] = st_reg.low_thr;
		status_word[opi_pkg::ST_HIGH_THR] = st_reg.high_thr;
		status_word[opi_pkg::ST_ROLE_B] = st_reg.role_b;
		status_word[opi_pkg::ST_READY_STYLE] = st_reg.ready_style;
		status_word[opi_pkg::ST_CLK_LSB +: 2] = st_reg.clk_src;
		status_word[opi_pkg::ST_TEST_LSB +: 3] = st_reg.test_code;
		status_word[opi_pkg::ST_TEST_EN] = st_reg.test_en;
		status_word[opi_pkg::ST_NORMAL] = normal_mode;
	end

	// Read mux; an unmapped index answers zero
	always_comb begin
		read_word = '0;
		if (dma_rd) begin
			read_word = dma_tx_word;
		end else begin
			unique case (pins.host_register_index)
				opi_pkg::IDX_PIN_CFG: begin
					read_word[opi_pkg::CFG_W-1:0] = st_reg.cfg;
				end
				opi_pkg::IDX_OTG_CTRL: begin
					read_word[opi_pkg::OTG_W-1:0] = st_reg.otg;
				end
				opi_pkg::IDX_PIN_STATUS: begin
					read_word = status_word;
				end
				default: begin
					read_word = '0;
				end
			endcase
		end
	end

	// Data bus: listen by default, drive only in a read cycle
	always_comb begin
		pins.dev_data_oe = reg_rd | dma_rd;
		pins.dev_data_out = read_word;
	end

	// ------------------------
	// Next state
	// ------------------------
	always_comb begin
		st_next = st_reg;
		st_next.rx_valid = 1'b0;
		// Straps are caught once the first clock after reset release
		if (!st_reg.straps_taken) begin
			st_next.straps_taken = 1'b1;
			st_next.ready_style = pins.ready_style_strap;
			st_next.clk_src = pins.clock_source_straps;
			st_next.test_code = pins.test_mode_straps;
		end
		// Level inputs follow the pins every cycle
		st_next.test_en = pins.test_enable_in;
		st_next.low_thr = pins.vbus_low_threshold_in;
		st_next.high_thr = pins.vbus_high_threshold_in;
		st_next.role_b = pins.otg_role_ident;
		// Register writes; status index ignores writes
		if (reg_wr) begin
			if (pins.host_register_index == opi_pkg::IDX_PIN_CFG) begin
				st_next.cfg = pins.host_data_bus[opi_pkg::CFG_W-1:0];
			end else if (pins.host_register_index == opi_pkg::IDX_OTG_CTRL) begin
				st_next.otg = pins.host_data_bus[opi_pkg::OTG_W-1:0];
			end
		end
		// DMA word captured from the shared bus
		if (dma_wr) begin
			st_next.rx_word = pins.host_data_bus;
			st_next.rx_valid = 1'b1;
		end
		// One pulse per rising strobe; a tied-low strobe gives none
		st_next.strobe_prev = pins.burst_dma_strobe;
		st_next.strobe_seen = pins.burst_dma_strobe & ~st_reg.strobe_prev;
	end

	// State register; everything resets to released or disabled
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			st_reg <= '0;
			st_reg.cfg <= opi_pkg::CFG_RESET;
			st_reg.otg <= opi_pkg::OTG_RESET;
		end else begin
			st_reg <= st_next;
		end
	end

	// ------------------------
	// CPU-side outputs
	// ------------------------
	// Request: released until enabled, then either polarity
	always_comb begin
		pins.dma_request_oe = st_reg.cfg[opi_pkg::CFG_DREQ_EN];
		pins.dma_request_out = st_reg.cfg[opi_pkg::CFG_DREQ_HIGH] ? dma_request : ~dma_request;
	end

	// Interrupt: active low; open-drain only pulls low while asserted
	always_comb begin
		pins.cpu_irq_out = ~irq_request;
		if (!st_reg.cfg[opi_pkg::CFG_IRQ_EN]) begin
			pins.cpu_irq_oe = 1'b0;
		end else if (st_reg.cfg[opi_pkg::CFG_IRQ_PP]) begin
			pins.cpu_irq_oe = 1'b1;
		end else begin
			pins.cpu_irq_oe = irq_request;
		end
	end

	// Hold: low while the access must wait. In ready style the pin
	// is only driven while the chip is selected or DMA is acknowledged,
	// so several devices may share one ready line on the board.
	logic hold_window; // Cycles in which the pin may be driven
	always_comb begin
		hold_window = st_reg.ready_style ? (cpu_sel | dma_sel) : 1'b1;
		pins.cpu_hold_out = ~hold_request;
		if (!st_reg.cfg[opi_pkg::CFG_HOLD_EN] || !hold_window) begin
			pins.cpu_hold_oe = 1'b0;
		end else if (st_reg.cfg[opi_pkg::CFG_HOLD_PP]) begin
			pins.cpu_hold_oe = 1'b1;
		end else begin
			pins.cpu_hold_oe = hold_request;
		end
	end

	// ------------------------
	// OTG outputs
	// ------------------------
	always_comb begin
		pins.vbus_3v3_enable = st_reg.otg[opi_pkg::OTG_VBUS_3V3];
		pins.vbus_5v_low_current_enable = st_reg.otg[opi_pkg::OTG_VBUS_5V_LC];
		pins.vbus_5v_high_current_enable = st_reg.otg[opi_pkg::OTG_VBUS_5V_HC];
		pins.dplus_pulldown_enable = st_reg.otg[opi_pkg::OTG_PULLDOWN];
		pins.dplus_pullup_enable_n = ~st_reg.otg[opi_pkg::OTG_PULLUP];
	end

	// ------------------------
	// User-side outputs
	// ------------------------
	always_comb begin
		dma_rx_word = st_reg.rx_word;
		dma_rx_valid = st_reg.rx_valid;
		dma_tx_taken = dma_rd;
		burst_strobe_seen = st_reg.strobe_seen;
		clock_source = st_reg.clk_src;
		role_is_b = st_reg.role_b;
		vbus_above_1v0 = st_reg.low_thr;
		vbus_above_2v2 = st_reg.high_thr;
		// Normal only with all test straps low and test enable low
		normal_mode = (st_reg.test_code == opi_pkg::TEST_NORMAL) & ~st_reg.test_en;
		ready_mode = st_reg.ready_style;
	end

endmodule
`default_nettype wire

/* File: tb/opi_properties.sv */
// Concurrent checks on the pins between the controller end and its CPU/board end
`timescale 1ns/1ps
`default_nettype none
module opi_checker (
	input wire logic clock,
	input wire logic rst_n,
	input wire logic chip_select_n,
	input wire logic cpu_read_strobe_n,
	input wire logic cpu_write_strobe_n,
	input wire logic [7:0] host_register_index,
	input wire logic dma_acknowledge_in,
	input wire logic [15:0] host_data_bus,
	input wire logic dev_data_oe,
	input wire logic dma_request_oe,
	input wire logic cpu_irq_oe,
	input wire logic cpu_hold_oe,
	input wire logic ready_style_strap,
	input wire logic [1:0] clock_source_straps,
	input wire logic [2:0] test_mode_straps,
	input wire logic test_enable_in,
	input wire logic vbus_3v3_enable,
	input wire logic vbus_5v_low_current_enable,
	input wire logic vbus_5v_high_current_enable,
	input wire logic dplus_pulldown_enable,
	input wire logic dplus_pullup_enable_n
);
	// ------------------------
	// Properties
	// ------------------------
	// One clock domain; rst_n is the device reset as the device sees it
	default clocking cb @(posedge clock); endclocking
	default disable iff (!rst_n);
	sequence s_stat;
		!chip_select_n && !cpu_read_strobe_n && host_register_index == opi_pkg::IDX_PIN_STATUS;
	endsequence
	// A register write that the device accepts, not shadowed by a DMA cycle
	sequence s_otg_wr;
		!chip_select_n && !cpu_write_strobe_n && dma_acknowledge_in && host_register_index == opi_pkg::IDX_OTG_CTRL;
	endsequence
	property p_req_rel; $rose(rst_n) |-> !dma_request_oe; endproperty
	property p_irq_rel; $rose(rst_n) |-> !cpu_irq_oe; endproperty
	property p_hold_rel; $rose(rst_n) |-> !cpu_hold_oe; endproperty
	property p_vbus_off;
		$rose(rst_n) |-> !vbus_3v3_enable && !vbus_5v_low_current_enable && !vbus_5v_high_current_enable;
	endproperty
	// Data bus only driven by the device during a selected or acknowledged read
	property p_data_dir; dev_data_oe |-> !cpu_read_strobe_n && (!chip_select_n || !dma_acknowledge_in); endproperty
	property p_ready; ready_style_strap && chip_select_n && dma_acknowledge_in |-> !cpu_hold_oe; endproperty
	property p_otg_wr;
		s_otg_wr |=> vbus_3v3_enable == $past(host_data_bus[opi_pkg::OTG_VBUS_3V3])
			&& dplus_pulldown_enable == $past(host_data_bus[opi_pkg::OTG_PULLDOWN]);
	endproperty
	// Pull-up pin is the inverse of the enable bit just written
	property p_pullup; s_otg_wr |=> dplus_pullup_enable_n != $past(host_data_bus[opi_pkg::OTG_PULLUP]); endproperty
	property p_normal;
		s_stat |-> host_data_bus[opi_pkg::ST_NORMAL] == (test_mode_straps == opi_pkg::TEST_NORMAL && !test_enable_in);
	endproperty
	property p_clk; s_stat |-> host_data_bus[opi_pkg::ST_CLK_LSB +: 2] == clock_source_straps; endproperty
	a_req_rel: assert property (p_req_rel) else $error("request pin driven after reset");
	a_irq_rel: assert property (p_irq_rel) else $error("interrupt pin driven after reset");
	a_hold_rel: assert property (p_hold_rel) else $error("hold pin driven after reset");
	a_vbus_off: assert property (p_vbus_off) else $error("supply enable on after reset");
	a_data_dir: assert property (p_data_dir) else $error("data bus driven outside a read");
	a_ready: assert property (p_ready) else $error("hold pin driven while idle in ready mode");
	a_otg_wr: assert property (p_otg_wr) else $error("supply or pull-down pin not following write");
	a_pullup: assert property (p_pullup) else $error("pull-up pin polarity wrong");
	a_normal: assert property (p_normal) else $error("normal mode decode wrong");
	a_clk: assert property (p_clk) else $error("clock source decode wrong");
	c_stat: cover property (s_stat);
	c_otg_wr: cover property (s_otg_wr);
	c_dma_rd: cover property (!dma_acknowledge_in && !cpu_read_strobe_n && dev_data_oe);
endmodule
`default_nettype wire

/* File: tb/otg_controller_pin_interface_bench.sv */
// Self-checking bench joining the controller end to its CPU/board end
`timescale 1ns/1ps
`default_nettype none
module otg_controller_pin_interface_bench;
	// ------------------------
	// Stimulus table and signals
	// ------------------------
	// ins holds dma, irq, hold requests then low, high thresholds and role
	typedef struct packed {logic [7:0] idx; logic [15:0] val; logic [5:0] ins; logic [3:0] ep;} opi_row_s;
	opi_row_s rows [6] = '{'{8'h00, 16'h0003, 6'h25, 4'h8}, '{8'h00, 16'h0001, 6'h37, 4'h0},
		'{8'h00, 16'h000D, 6'h10, 4'hE}, '{8'h00, 16'h0034, 6'h1C, 4'hE},
		'{8'h01, 16'h0015, 6'h03, 4'h8}, '{8'h01, 16'h000A, 6'h04, 4'h8}};
	logic clock = 1'h0;
	logic rst_n = 1'h0;
	logic [7:0] cmd_addr = 8'h00;
	logic [15:0] cmd_wdata = 16'h0000;
	logic [15:0] dma_tx_word = 16'h3C5A; // Word the device offers on a DMA read
	logic cmd_write = 1'h0, cmd_read = 1'h0, dma_write = 1'h0, dma_read = 1'h0;
	logic burst_mode = 1'h0, burst_pulse = 1'h0, clock_stable = 1'h0, int_cmp = 1'h0;
	logic [5:0] ins = 6'h00;
	logic [15:0] cmd_rdata, dma_rx_word, rd;
	logic dma_rx_valid, burst_seen, dreq_seen, irq_seen, hold_seen;
	logic [4:0] otg_m = 5'h00; // Last OTG control value written
	int err_count = 0, n_checks = 0, n;
	opi_if ifc();
	wire logic dev_rst_n;
	wire logic [6:0] dv; // Clock source, role, thresholds, normal and ready decode
	wire logic tx_taken;
	// Device is held by the bench reset and by the board chip reset
	assign dev_rst_n = rst_n & ifc.chip_reset_n;
	always #5 clock = ~clock;
	opi_device opi_device_inst (.clock(clock), .rst_n(dev_rst_n), .pins(ifc), .irq_request(ins[4]),
		.dma_request(ins[5]), .hold_request(ins[3]), .dma_tx_word(dma_tx_word), .dma_rx_word(dma_rx_word),
		.dma_rx_valid(dma_rx_valid), .dma_tx_taken(tx_taken), .burst_strobe_seen(burst_seen),
		.clock_source(dv[6:5]), .role_is_b(dv[4]), .vbus_above_1v0(dv[3]), .vbus_above_2v2(dv[2]),
		.normal_mode(dv[1]), .ready_mode(dv[0]));
	opi_host #(.READY_STYLE(1'h1), .CLOCK_SOURCE(2'h2)) opi_host_inst (.clock(clock), .rst_n(rst_n),
		.pins(ifc), .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata), .cmd_write(cmd_write), .cmd_read(cmd_read),
		.cmd_rdata(cmd_rdata), .dma_write(dma_write), .dma_read(dma_read), .burst_mode(burst_mode),
		.burst_pulse(burst_pulse), .clock_stable(clock_stable), .use_internal_comparator(int_cmp),
		.low_threshold(ins[2]), .high_threshold(ins[1]), .vbus_half_level(1'h0), .role_ident(ins[0]),
		.dma_request_seen(dreq_seen), .irq_seen(irq_seen), .hold_seen(hold_seen));
	opi_checker opi_checker_inst (.clock(clock), .rst_n(dev_rst_n), .chip_select_n(ifc.chip_select_n),
		.cpu_read_strobe_n(ifc.cpu_read_strobe_n), .cpu_write_strobe_n(ifc.cpu_write_strobe_n),
		.host_register_index(ifc.host_register_index), .dma_acknowledge_in(ifc.dma_acknowledge_in),
		.host_data_bus(ifc.host_data_bus), .dev_data_oe(ifc.dev_data_oe), .dma_request_oe(ifc.dma_request_oe),
		.cpu_irq_oe(ifc.cpu_irq_oe), .cpu_hold_oe(ifc.cpu_hold_oe), .ready_style_strap(ifc.ready_style_strap),
		.clock_source_straps(ifc.clock_source_straps), .test_mode_straps(ifc.test_mode_straps),
		.test_enable_in(ifc.test_enable_in), .vbus_3v3_enable(ifc.vbus_3v3_enable),
		.vbus_5v_low_current_enable(ifc.vbus_5v_low_current_enable),
		.vbus_5v_high_current_enable(ifc.vbus_5v_high_current_enable),
		.dplus_pulldown_enable(ifc.dplus_pulldown_enable), .dplus_pullup_enable_n(ifc.dplus_pullup_enable_n));
	// ------------------------
	// Tasks
	// ------------------------
	task automatic chk_word(input logic [15:0] got, input logic [15:0] exp);
		n_checks++;
		if (got !== exp) begin
			err_count++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// One-cycle write strobe; dma selects the acknowledged path instead of chip select
	task automatic wr(input logic dma, input logic [7:0] a, input logic [15:0] d);
		@(posedge clock);
		cmd_addr <= a;
		cmd_wdata <= d;
		cmd_write <= ~dma;
		dma_write <= dma;
		@(posedge clock);
		cmd_write <= 1'h0;
		dma_write <= 1'h0;
		#1;
	endtask
	// Read data stand only in the cycle after the strobe
	task automatic rdx(input logic dma, input logic [7:0] a, output logic [15:0] d);
		@(posedge clock);
		cmd_addr <= a;
		cmd_read <= ~dma;
		dma_read <= dma;
		@(posedge clock);
		cmd_read <= 1'h0;
		dma_read <= 1'h0;
		#1 d = cmd_rdata;
	endtask
	// Released pins, disabled supplies, pull-up off
	task automatic chk_idle();
		chk_word({7'h0, ifc.dev_data_oe, ifc.dma_request_oe, ifc.cpu_irq_oe, ifc.cpu_hold_oe, ifc.vbus_3v3_enable,
			ifc.vbus_5v_low_current_enable, ifc.vbus_5v_high_current_enable, ifc.dplus_pulldown_enable,
			ifc.dplus_pullup_enable_n}, 16'h0001);
	endtask
	task automatic print_verdict();
		$display("checks=%0d errors=%0d", n_checks, err_count);
		if (err_count == 0 && n_checks > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask
	// ------------------------
	// Main sequence
	// ------------------------
	initial begin
		repeat (5) @(posedge clock);
		rst_n <= 1'h1;
		@(posedge clock);
		clock_stable <= 1'h1;
		repeat (4) @(posedge clock);
		foreach (rows[i]) begin
			@(posedge clock);
			ins <= rows[i].ins;
			wr(1'h0, rows[i].idx, rows[i].val);
			if (rows[i].idx == opi_pkg::IDX_OTG_CTRL) otg_m = rows[i].val[4:0];
			chk_word({12'h0, dreq_seen, irq_seen, ifc.cpu_irq_oe, ifc.cpu_hold_oe}, {12'h0, rows[i].ep});
			chk_word({11'h0, ifc.dplus_pullup_enable_n, ifc.dplus_pulldown_enable, ifc.vbus_5v_high_current_enable,
				ifc.vbus_5v_low_current_enable, ifc.vbus_3v3_enable}, {11'h0, ~otg_m[4], otg_m[3:0]});
			rdx(1'h0, rows[i].idx, rd);
			chk_word(rd, rows[i].val);
			rdx(1'h0, opi_pkg::IDX_PIN_STATUS, rd);
			chk_word(rd, {5'h0, 1'h1, 4'h0, 2'h2, 1'h1, rows[i].ins[0], rows[i].ins[1], rows[i].ins[2]});
			chk_word({9'h0, dv}, {9'h0, 2'h2, rows[i].ins[0], rows[i].ins[2], rows[i].ins[1], 2'h3});
		end
		// DMA write and read share the data bus
		wr(1'h1, 8'h00, 16'hA5C3);
		chk_word({15'h0, dma_rx_valid}, 16'h0001);
		chk_word(dma_rx_word, 16'hA5C3);
		rdx(1'h1, 8'h00, rd);
		chk_word(rd, 16'h3C5A);
		// Unmapped index reads zero; status ignores writes
		rdx(1'h0, 8'h7F, rd);
		chk_word(rd, 16'h0000);
		wr(1'h0, opi_pkg::IDX_PIN_STATUS, 16'hFFFF);
		rdx(1'h0, opi_pkg::IDX_PIN_STATUS, rd);
		chk_word(rd, 16'h0429);
		// In ready style the hold pin is driven only inside an access
		@(posedge clock);
		dma_read <= 1'h1;
		ins <= 6'h08;
		#1 chk_word({14'h0, tx_taken, hold_seen}, 16'h0003);
		// One strobe edge gives exactly one pulse
		@(posedge clock);
		dma_read <= 1'h0;
		burst_mode <= 1'h1;
		burst_pulse <= 1'h1;
		n = 0;
		repeat (4) begin
			@(posedge clock);
			#1 n += int'(burst_seen);
		end
		chk_word(16'(n), 16'h0001);
		// Mid-run reset with the low-current 5 V supply on; internal comparator grounds thresholds
		@(posedge clock);
		burst_pulse <= 1'h0;
		int_cmp <= 1'h1;
		ins <= 6'h06;
		rst_n <= 1'h0;
		#1 chk_idle();
		repeat (2) @(posedge clock);
		rst_n <= 1'h1;
		repeat (4) @(posedge clock);
		#1 chk_idle();
		chk_word({14'h0, dv[3:2]}, 16'h0000);
		print_verdict();
	end
	// Whole run needs well under a thousand cycles
	initial begin
		#50000;
		err_count++;
		print_verdict();
	end
endmodule
`default_nettype wire
